// >>> design/usm_consts.svh
// usm_consts.svh: register offsets, field positions and reset values
// for the usb signal pin mux; included by the package and the module.
`ifndef USM_CONSTS_SVH
`define USM_CONSTS_SVH

// register byte offsets on the apb bus
`define USM_OFF_MODE 12'h000
`define USM_OFF_PIN 12'h004
`define USM_OFF_STAT 12'h008

// mode control register fields
`define USM_MODE_LSB 0
`define USM_MODE_W 7
`define USM_HCEN_BIT 8

// mux mode codes
`define USM_MODE_PASS 7'h07
`define USM_MODE_SER_A 7'h02
`define USM_MODE_SER_B 7'h0A
`define USM_MODE_SER_C 7'h12
`define USM_MODE_SER_D 7'h18

// pin control register fields
`define USM_PIN_MUXSEL_BIT 0
`define USM_PIN_PUCFG_LSB 1
`define USM_PIN_FUNC_LSB 3
`define USM_PIN_PDDIS_BIT 6
`define USM_PIN_SUSP_BIT 7
`define USM_PIN_W 8

// pin function codes for the pullup control pin
`define USM_FUNC_PULLUP 3'h0
`define USM_FUNC_HUBCLK 3'h1

// reset values
`define USM_RST_MODE 7'h00
`define USM_RST_PIN 8'h00

// edges after reset release before the strap is taken
`define USM_STRAP_DELAY 2'h2

`endif

// >>> design/usm_pkg.sv
// usm_pkg: types shared by the usb signal pin mux.
// assumes usm_consts.svh is on the include path.
package usm_pkg;
  `include "usm_consts.svh"

  typedef logic [`USM_MODE_W-1:0] usm_mode_t;
  typedef logic [1:0] usm_pucfg_t;
  typedef logic [2:0] usm_func_t;

  // which routing the six mux-owned pins follow
  typedef enum logic [1:0] {
    USM_ROUTE_IDLE,
    USM_ROUTE_PASS,
    USM_ROUTE_SERIAL
  } usm_route_e;
endpackage

// >>> design/usm_pin_mux.sv
// usm_pin_mux: usb signal pin mux with apb register access, pullup pin
// drive, passthrough and serial routing, and the shared boot strap pin.
// assumes a single 100 MHz pclk and an apb master on the same clock;
// pin paths are combinational by intent, the strap alone is synchronised.
//
// Operation
// - mode 7 with mux selected forwards pins
// - port1 se0 from p2 plus, txen from p2 rcv
// - port1 txd from p2 minus, p2 se0 from p1 plus
// - port2 txen from p1 rcv, txd from p1 minus
// - modes 2,10,18,24 route serial1 through mux pins
// - serial tx out on txd, rx/cts in
// - config 0 drives low when pullup active
// - config 1 outputs clock on pullup pin
// - config 2 drives high when pullup active
// - config 3 drives high or floats
// - strap sampled at reset selects boot memory
// - strap pin reusable as suspend output later
// - weak pulldown on by default, disableable
// - host clock enable leaves routing unchanged
// - function field 000 pullup, 001 hub clock
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "usm_consts.svh"

module usm_pin_mux
  import usm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // passthrough and serial input pins
  input wire logic port2_plus_line_in_pin,
  input wire logic port2_diff_receive_in_pin,
  input wire logic port2_minus_line_in_pin,
  input wire logic port1_plus_line_in_pin,
  input wire logic port1_diff_receive_in_pin,
  input wire logic port1_minus_line_in_pin,
  input wire logic port1_minus_line_serial_pin,
  // mux-owned output pins
  output logic port1_single_ended_zero_out_pin,
  output logic port1_single_ended_zero_oe,
  output logic port1_tx_enable_out_pin,
  output logic port1_tx_enable_oe,
  output logic port1_tx_data_out_pin,
  output logic port1_tx_data_oe,
  output logic port2_single_ended_zero_out_pin,
  output logic port2_single_ended_zero_oe,
  output logic port2_tx_enable_out_pin,
  output logic port2_tx_enable_oe,
  output logic port2_tx_data_out_pin,
  output logic port2_tx_data_oe,
  // serial port 1 side
  input wire logic serial1_transmit,
  output logic serial1_receive,
  output logic serial1_clear_to_send,
  // pullup control pin
  input wire logic pullup_active,
  input wire logic hub_clock_output,
  output logic dplus_pullup_control_pin,
  output logic dplus_pullup_control_oe,
  // shared boot strap / suspend pin
  input wire logic boot_strap_suspend_pin_in,
  input wire logic port1_suspend_output,
  output logic boot_strap_suspend_pin_out,
  output logic boot_strap_suspend_pin_oe,
  output logic boot_strap_pulldown_en,
  // boot selection and host clock request
  output logic boot_overlay_select,
  output logic host_ctrl_clock_enable
);

  function automatic logic is_serial_mode(input usm_mode_t m);
    is_serial_mode = (m == `USM_MODE_SER_A) || (m == `USM_MODE_SER_B) ||
                     (m == `USM_MODE_SER_C) || (m == `USM_MODE_SER_D);
  endfunction

  // register state
  usm_mode_t mode_q;
  logic hcen_q;
  logic [`USM_PIN_W-1:0] pin_q;
  logic [31:0] prdata_q;
  logic strap_s1_q;
  logic strap_s2_q;
  logic [1:0] rel_cnt_q;
  logic strap_done_q;
  logic boot_q;

  // apb decode
  wire logic setup_ph = psel && !penable;
  wire logic hit_mode = (paddr == `USM_OFF_MODE);
  wire logic hit_pin = (paddr == `USM_OFF_PIN);
  wire logic hit_stat = (paddr == `USM_OFF_STAT);
  wire logic hit_any = hit_mode || hit_pin || hit_stat;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic wr_mode_lo = wr_acc && hit_mode && pstrb[0];
  wire logic wr_mode_hi = wr_acc && hit_mode && pstrb[1];
  wire logic wr_pin = wr_acc && hit_pin && pstrb[0];

  wire logic [31:0] rd_mode = {23'h0, hcen_q, 1'b0, mode_q};
  wire logic [31:0] rd_pin = {24'h0, pin_q};
  wire logic [31:0] rd_stat = {30'h0, strap_done_q, boot_q};
  wire logic [31:0] rd_mux = hit_mode ? rd_mode :
                             hit_pin ? rd_pin :
                             hit_stat ? rd_stat : 32'h0;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `USM_RST_MODE;
    end else if (wr_mode_lo) begin
      mode_q <= pwdata[`USM_MODE_LSB +: `USM_MODE_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcen_q <= 1'b0;
    end else if (wr_mode_hi) begin
      hcen_q <= pwdata[`USM_HCEN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= `USM_RST_PIN;
    end else if (wr_pin) begin
      pin_q <= pwdata[`USM_PIN_W-1:0];
    end
  end

  // read data is latched in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // host clock request only; it feeds nothing in the routing below
  assign host_ctrl_clock_enable = hcen_q;

  // pin control fields
  wire logic mux_sel = pin_q[`USM_PIN_MUXSEL_BIT];
  wire usm_pucfg_t pu_cfg = pin_q[`USM_PIN_PUCFG_LSB +: 2];
  wire usm_func_t pu_func = pin_q[`USM_PIN_FUNC_LSB +: 3];
  wire logic pd_dis = pin_q[`USM_PIN_PDDIS_BIT];
  wire logic susp_fn = pin_q[`USM_PIN_SUSP_BIT];

  // routing choice depends only on mode and top-level select
  wire logic pass_on = mux_sel && (mode_q == `USM_MODE_PASS);
  wire logic serial_on = mux_sel && is_serial_mode(mode_q);
  wire usm_route_e route = pass_on ? USM_ROUTE_PASS :
                           serial_on ? USM_ROUTE_SERIAL : USM_ROUTE_IDLE;

  // passthrough wiring, no register in the path
  assign port1_single_ended_zero_out_pin =
    (route == USM_ROUTE_PASS) && port2_plus_line_in_pin;
  assign port1_single_ended_zero_oe = (route == USM_ROUTE_PASS);
  assign port1_tx_enable_out_pin =
    (route == USM_ROUTE_PASS) && port2_diff_receive_in_pin;
  assign port1_tx_enable_oe = (route == USM_ROUTE_PASS);
  assign port2_single_ended_zero_out_pin =
    (route == USM_ROUTE_PASS) && port1_plus_line_in_pin;
  assign port2_single_ended_zero_oe = (route == USM_ROUTE_PASS);
  assign port2_tx_enable_out_pin =
    (route == USM_ROUTE_PASS) && port1_diff_receive_in_pin;
  assign port2_tx_enable_oe = (route == USM_ROUTE_PASS);
  assign port2_tx_data_out_pin =
    (route == USM_ROUTE_PASS) && port1_minus_line_in_pin;
  assign port2_tx_data_oe = (route == USM_ROUTE_PASS);

  // port1 txd is shared between passthrough and serial transmit
  assign port1_tx_data_out_pin =
    (route == USM_ROUTE_PASS) ? port2_minus_line_in_pin :
    (route == USM_ROUTE_SERIAL) ? serial1_transmit : 1'b0;
  assign port1_tx_data_oe = (route != USM_ROUTE_IDLE);

  // serial inputs idle high (mark) when not routed
  assign serial1_receive =
    (route == USM_ROUTE_SERIAL) ? port1_minus_line_serial_pin : 1'b1;
  assign serial1_clear_to_send =
    (route == USM_ROUTE_SERIAL) ? port1_diff_receive_in_pin : 1'b1;

  // pullup control pin drive
  wire logic pu_clk_sel = (pu_func == `USM_FUNC_HUBCLK) || (pu_cfg == 2'h1);
  wire logic pu_ctl_sel = (pu_func == `USM_FUNC_PULLUP);
  wire logic pu_level = (pu_cfg == 2'h0) ? !pullup_active : pullup_active;
  assign dplus_pullup_control_pin =
    pu_clk_sel ? hub_clock_output : (pu_ctl_sel && pu_level);
  assign dplus_pullup_control_oe =
    pu_clk_sel || !pu_ctl_sel || (pu_cfg != 2'h3) || pullup_active;

  // strap pin passes two flops before it is sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= boot_strap_suspend_pin_in;
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt_q <= 2'h0;
    end else if (rel_cnt_q != `USM_STRAP_DELAY) begin
      rel_cnt_q <= rel_cnt_q + 2'h1;
    end
  end

  // strap taken once after reset release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'b0;
      boot_q <= 1'b0;
    end else if (!strap_done_q && rel_cnt_q == `USM_STRAP_DELAY) begin
      strap_done_q <= 1'b1;
      boot_q <= strap_s2_q;
    end
  end

  assign boot_overlay_select = boot_q;
  assign boot_strap_suspend_pin_oe = strap_done_q && susp_fn;
  assign boot_strap_suspend_pin_out =
    strap_done_q && susp_fn && port1_suspend_output;
  assign boot_strap_pulldown_en = !pd_dis;

  // checks on the routing and pin behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pass_oe_on: assert property (pass_on |-> port1_single_ended_zero_oe &&
    port1_tx_enable_oe && port1_tx_data_oe && port2_single_ended_zero_oe &&
    port2_tx_enable_oe && port2_tx_data_oe)
    else $error("passthrough outputs not enabled");
  a_pass_port1: assert property (pass_on |->
    port1_single_ended_zero_out_pin == port2_plus_line_in_pin &&
    port1_tx_enable_out_pin == port2_diff_receive_in_pin)
    else $error("port1 se0 or txen not forwarded");
  a_pass_txd_se0: assert property (pass_on |->
    port1_tx_data_out_pin == port2_minus_line_in_pin &&
    port2_single_ended_zero_out_pin == port1_plus_line_in_pin)
    else $error("port1 txd or port2 se0 not forwarded");
  a_pass_port2: assert property (pass_on |->
    port2_tx_enable_out_pin == port1_diff_receive_in_pin &&
    port2_tx_data_out_pin == port1_minus_line_in_pin)
    else $error("port2 txen or txd not forwarded");
  a_serial_gate: assert property (!mux_sel |-> !port1_tx_data_oe &&
    serial1_receive && serial1_clear_to_send)
    else $error("mux pins active without top select");
  a_serial_route: assert property (serial_on |-> port1_tx_data_oe &&
    port1_tx_data_out_pin == serial1_transmit &&
    serial1_receive == port1_minus_line_serial_pin &&
    serial1_clear_to_send == port1_diff_receive_in_pin && !port2_tx_data_oe)
    else $error("serial routing wrong");
  a_pullup_cfg0: assert property (pu_ctl_sel && pu_cfg == 2'h0 |->
    dplus_pullup_control_oe && dplus_pullup_control_pin == !pullup_active)
    else $error("config 0 pullup level wrong");
  a_pullup_clock: assert property (pu_clk_sel |-> dplus_pullup_control_oe &&
    dplus_pullup_control_pin == hub_clock_output)
    else $error("hub clock not on pullup pin");
  a_pullup_cfg2: assert property (pu_ctl_sel && pu_cfg == 2'h2 |->
    dplus_pullup_control_oe && dplus_pullup_control_pin == pullup_active)
    else $error("config 2 pullup level wrong");
  a_pullup_cfg3: assert property (pu_ctl_sel && pu_cfg == 2'h3 |->
    dplus_pullup_control_oe == pullup_active &&
    (!pullup_active || dplus_pullup_control_pin))
    else $error("config 3 pullup drive wrong");
  a_strap_taken: assert property ($rose(strap_done_q) |->
    boot_overlay_select == $past(strap_s2_q))
    else $error("strap not captured");
  a_strap_frozen: assert property (strap_done_q && $past(strap_done_q) |->
    $stable(boot_overlay_select))
    else $error("boot selection changed after capture");
  a_suspend_use: assert property (!strap_done_q |-> !boot_strap_suspend_pin_oe)
    else $error("strap pin driven before capture");
  a_pulldown_en: assert property (boot_strap_pulldown_en == !pd_dis)
    else $error("pulldown enable wrong");
  a_hcen_route: assert property ($changed(hcen_q) && $stable(pin_q) &&
    $stable(mode_q) |-> route == $past(route))
    else $error("host clock enable changed routing");
  a_func_hub: assert property (pu_func == `USM_FUNC_HUBCLK |->
    dplus_pullup_control_pin == hub_clock_output)
    else $error("function 001 not hub clock");

  c_pass_mode: cover property (pass_on ##1 pass_on);
  c_serial_mode: cover property (serial_on && serial1_transmit);
  c_cfg3_float: cover property (pu_ctl_sel && pu_cfg == 2'h3 && !pullup_active);
  c_overlay_boot: cover property ($rose(strap_done_q) && strap_s2_q);

endmodule // usm_pin_mux

`default_nettype wire

// >>> test/usm_board.sv
// usm_board: transceivers and board parts at the usb mux pins.
// assumes the bench sets transceiver levels and whether the strap pullup is fitted.
`timescale 1ns/1ns
`default_nettype none

module usm_board (
  // bench side
  input wire logic [6:0] xcvr_val,
  input wire logic strap_pu,
  output logic [6:0] xcvr_pin,
  output logic dplus_lvl,
  output logic strap_lvl,
  // device pins
  input wire logic dplus_out,
  input wire logic dplus_oe,
  input wire logic strap_out,
  input wire logic strap_oe,
  input wire logic strap_pd
);
  assign xcvr_pin = xcvr_val;
  // an undriven pullup pin sits at the d+ side pulldown
  assign dplus_lvl = dplus_oe ? dplus_out : 1'b0;
  // an external pullup beats the weak internal pulldown
  assign strap_lvl = strap_oe ? strap_out : (strap_pu | !strap_pd);
endmodule // usm_board
`default_nettype wire

// >>> test/usm_pin_mux_test.sv
// usm_pin_mux_test: self-checking bench for the usb signal pin mux.
// assumes usm_consts.svh on the include path and usm_board as far side.
`timescale 1ns/1ns
`default_nettype none

module usm_pin_mux_test;
  import usm_pkg::*;
  `include "usm_consts.svh"
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr;
  logic port2_plus_line_in_pin, port2_diff_receive_in_pin, port2_minus_line_in_pin,
    port1_plus_line_in_pin, port1_diff_receive_in_pin, port1_minus_line_in_pin,
    port1_minus_line_serial_pin;
  logic port1_single_ended_zero_out_pin, port1_single_ended_zero_oe, port1_tx_enable_out_pin,
    port1_tx_enable_oe, port1_tx_data_out_pin, port1_tx_data_oe,
    port2_single_ended_zero_out_pin, port2_single_ended_zero_oe, port2_tx_enable_out_pin,
    port2_tx_enable_oe, port2_tx_data_out_pin, port2_tx_data_oe, serial1_receive,
    serial1_clear_to_send;
  logic serial1_transmit = 0, pullup_active = 0, hub_clock_output = 0;
  logic port1_suspend_output = 0, strap_pu = 0, dlvl, slvl, last_err;
  logic dplus_pullup_control_pin, dplus_pullup_control_oe, boot_strap_suspend_pin_out,
    boot_strap_suspend_pin_oe, boot_strap_pulldown_en, boot_overlay_select,
    host_ctrl_clock_enable;
  logic [6:0] xv = 7'h00;
  wire [6:0] xp;
  int fail_count = 0, num_checks = 0, mode_m, pin_m;
  wire [13:0] route_seen = {port1_single_ended_zero_out_pin, port1_single_ended_zero_oe,
    port1_tx_enable_out_pin, port1_tx_enable_oe, port1_tx_data_out_pin, port1_tx_data_oe,
    port2_single_ended_zero_out_pin, port2_single_ended_zero_oe, port2_tx_enable_out_pin,
    port2_tx_enable_oe, port2_tx_data_out_pin, port2_tx_data_oe, serial1_receive,
    serial1_clear_to_send};

  assign {port2_plus_line_in_pin, port2_diff_receive_in_pin, port2_minus_line_in_pin,
    port1_plus_line_in_pin, port1_diff_receive_in_pin, port1_minus_line_in_pin,
    port1_minus_line_serial_pin} = xp;

  always #5 pclk = ~pclk;

  usm_pin_mux i_usm_pin_mux (.*, .boot_strap_suspend_pin_in(slvl));

  usm_board i_usm_board (.xcvr_val(xv), .strap_pu(strap_pu), .xcvr_pin(xp), .dplus_lvl(dlvl),
    .strap_lvl(slvl), .dplus_out(dplus_pullup_control_pin), .dplus_oe(dplus_pullup_control_oe),
    .strap_out(boot_strap_suspend_pin_out), .strap_oe(boot_strap_suspend_pin_oe),
    .strap_pd(boot_strap_pulldown_en));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, pready);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected {out,oe} of the six mux pins, then serial rx and cts
  function automatic logic [13:0] route_exp(int m, int p, logic [6:0] x, logic t);
    logic [13:0] e;
    e = 14'h0003;
    if (p[0] && m == 7) e = {x[6], 1'b1, x[5], 1'b1, x[4], 1'b1, x[3], 1'b1, x[2], 1'b1,
      x[1], 1'b1, 2'h3};
    else if (p[0] && (m == 2 || m == 10 || m == 18 || m == 24))
      e = {4'h0, t, 1'b1, 6'h00, x[0], x[2]};
    return e;
  endfunction

  // expected {oe, wire level} of the pullup control pin
  function automatic logic [1:0] pu_exp(int p, logic a, logic c);
    int cf, fn;
    cf = (p >> 1) & 3;
    fn = (p >> 3) & 7;
    if (fn == 1 || cf == 1) return {1'b1, c};
    if (fn != 0) return 2'h2;
    case (cf)
      0: return {1'b1, !a};
      2: return {1'b1, a};
      default: return {a, a};
    endcase
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    int modes[7];
    logic [13:0] exp_r;
    modes = '{0, 7, 2, 10, 18, 24, 5};
    void'($urandom(79));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pulldown_rst", 1, boot_strap_pulldown_en); // default pulldown on
    chk("overlay_low", 0, boot_overlay_select); // low strap
    apb(0, `USM_OFF_STAT, 0, r);
    chk("stat_rst", 32'h2, r); // strap taken low
    apb(0, `USM_OFF_PIN, 0, r);
    chk("pin_rst", 0, r); // function field default
    $display("test reset done");
    foreach (modes[i]) for (int s = 0; s < 2; s++) begin
      mode_m = modes[i] + 256 * $urandom_range(1, 0);
      apb(1, `USM_OFF_MODE, mode_m, r);
      apb(1, `USM_OFF_PIN, s, r);
      apb(0, `USM_OFF_MODE, 0, r);
      chk("mode_rd", mode_m, r);
      repeat (4) begin
        @(posedge pclk);
        xv <= 7'($urandom);
        serial1_transmit <= 1'($urandom);
        #1;
        exp_r = route_exp(mode_m & 127, s, xv, serial1_transmit);
        chk("route", exp_r, route_seen);
        chk("host_clk", mode_m >> 8, host_ctrl_clock_enable); // host clock enable follows mode bit 8
      end
    end
    $display("test routing done");
    for (int f = 0; f < 3; f++) for (int c = 0; c < 4; c++) begin
      pin_m = f * 8 + c * 2 + 1;
      apb(1, `USM_OFF_PIN, pin_m, r);
      repeat (4) begin
        @(posedge pclk);
        pullup_active <= 1'($urandom);
        hub_clock_output <= 1'($urandom);
        #1;
        chk("pullup_pin", pu_exp(pin_m, pullup_active, hub_clock_output),
          {dplus_pullup_control_oe, dlvl});
      end
    end
    $display("test pullup done");
    apb(1, `USM_OFF_PIN, 32'h80, r);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      port1_suspend_output <= 1'(v);
      #1;
      chk("suspend", {1'b1, 1'(v)}, {boot_strap_suspend_pin_oe, slvl});
    end
    apb(1, `USM_OFF_PIN, 32'h40, r);
    @(posedge pclk);
    chk("pulldown_off", 0, boot_strap_pulldown_en);
    apb(0, 12'h00C, 0, r);
    chk("unmapped_err", 1, last_err);
    chk("unmapped_rd", 0, r);
    apb(1, `USM_OFF_STAT, 0, r);
    apb(0, `USM_OFF_STAT, 0, r);
    chk("stat_ro", 32'h2, r);
    // low byte lane only: mode changes, host clock bit keeps its value
    pstrb <= 4'h1;
    apb(1, `USM_OFF_MODE, 32'h107, r);
    pstrb <= 4'hF;
    apb(0, `USM_OFF_MODE, 0, r);
    chk("mode_strb", 7 + (mode_m & 256), r);
    strap_pu <= 1'b1;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("overlay_high", 1, boot_overlay_select); // pulled-up strap
    apb(0, `USM_OFF_STAT, 0, r);
    chk("stat_overlay", 32'h3, r);
    apb(0, `USM_OFF_MODE, 0, r);
    chk("mode_cleared", 0, r);
    $display("test strap done");
    conclude();
  end
endmodule // usm_pin_mux_test
`default_nettype wire
